// *** psic_ctrl.sv ***
// Power-save gatekeeper, idle entry/exit and watchdog autostart.
// Expects the core to pulse instr_end once per completed instruction and
// to present SFR writes with that instruction's data.
`timescale 1ns/1ns
module psic_ctrl
  import psic_pkg::*;
(
  input  wire logic         sys_clk,
  input  wire logic         rst_b,
  input  wire logic         power_save_permit_pin,
  input  wire logic         permit_pin_connected,
  input  wire logic [2:0]   cyc_state,
  input  wire logic         cyc_phase,
  input  wire logic         instr_end,
  input  wire psic_sfr_wr_t sfr_wr,
  input  wire logic         irq_pending,
  input  wire logic         ext_code_fetch,
  input  wire logic         core_ale,
  input  wire logic         core_prog_strobe,
  output logic              cpu_clk_en,
  output logic              wdt_clk_en,
  output logic              wdt_auto_start,
  output logic              idle_active,
  output logic              deep_stop_active,
  output logic              save_permitted,
  output logic [7:0]        power_control_reg,
  output psic_pins_t        pins
);

  // ============================================================
  // Permit pin sampling.
  logic       pin_lvl;
  logic       permit_ff;
  logic       nxt_permit;
  logic       wdt_auto_ff;
  logic       nxt_wdt_auto;
  logic       rst_seen_ff;
  logic       nxt_rst_seen;

  // An open pin is pulled high, which blocks the modes.
  assign pin_lvl = permit_pin_connected ? power_save_permit_pin : 1'b1;

  function automatic logic sample_slot(input logic [2:0] st,
                                       input logic       ph);
    sample_slot = (st == SAMPLE_STATE) && (ph == SAMPLE_PHASE);
  endfunction : sample_slot

  always_comb begin
    nxt_permit   = permit_ff;
    nxt_wdt_auto = wdt_auto_ff;
    nxt_rst_seen = 1'b1;
    if (sample_slot(cyc_state, cyc_phase)) begin
      nxt_permit = ~pin_lvl;
    end
    // The strap is caught on the first edge after release, never again,
    // so later pin activity cannot start or stop the watchdog.
    if (!rst_seen_ff) begin
      nxt_wdt_auto = pin_lvl;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      permit_ff   <= 1'b0;
      wdt_auto_ff <= 1'b0;
      rst_seen_ff <= 1'b0;
    end else begin
      permit_ff   <= nxt_permit;
      wdt_auto_ff <= nxt_wdt_auto;
      rst_seen_ff <= nxt_rst_seen;
    end
  end

  // ============================================================
  // Register and entry sequence.
  logic       power_control_reg_wr;
  logic       wr_sl_arm;
  logic       wr_sl_start;
  logic       wr_dp_arm;
  logic       wr_dp_start;
  logic       permit_now;
  logic [7:0] power_control_reg_ff;
  logic [7:0] nxt_power_control_reg;
  logic       sl_arm_ff;
  logic       nxt_sl_arm;
  logic       dp_arm_ff;
  logic       nxt_dp_arm;
  psic_mode_t mode_ff;
  psic_mode_t nxt_mode;

  assign power_control_reg_wr     = sfr_wr.wr && (sfr_wr.addr == PWR_CTRL_ADDR);
  assign wr_sl_arm   = power_control_reg_wr && sfr_wr.data[BIT_SLEEP_ARM];
  assign wr_sl_start = power_control_reg_wr && sfr_wr.data[BIT_SLEEP_START];
  assign wr_dp_arm   = power_control_reg_wr && sfr_wr.data[BIT_DEEP_ARM];
  assign wr_dp_start = power_control_reg_wr && sfr_wr.data[BIT_DEEP_START];
  // Use the level sampled in this very cycle if the slot is now.
  assign permit_now  = nxt_permit;

  always_comb begin
    nxt_power_control_reg   = power_control_reg_ff;
    nxt_sl_arm = sl_arm_ff;
    nxt_dp_arm = dp_arm_ff;
    nxt_mode   = mode_ff;
    if (power_control_reg_wr) begin
      // Arm and start bits never store, so they always read zero.
      nxt_power_control_reg = sfr_wr.data & ~PWR_SELF_CLR;
    end
    // An arm lives only until the next instruction ends.
    if (instr_end) begin
      nxt_sl_arm = wr_sl_arm && !wr_sl_start;
      nxt_dp_arm = wr_dp_arm && !wr_dp_start;
    end
    case (mode_ff)
      PSIC_RUN: begin
        if (instr_end && permit_now) begin
          // Deep stop beats idle when both start together.
          if (dp_arm_ff && wr_dp_start && !wr_dp_arm) begin
            nxt_mode = PSIC_DEEP;
          end else if (sl_arm_ff && wr_sl_start && !wr_sl_arm) begin
            nxt_mode = PSIC_IDLE;
          end
        end
      end
      PSIC_IDLE: begin
        if (irq_pending) begin
          nxt_mode = PSIC_RUN;
        end
      end
      PSIC_DEEP: begin
        nxt_mode = PSIC_DEEP;
      end
      default: begin
        nxt_mode = PSIC_RUN;
      end
    endcase
    if (nxt_mode != PSIC_RUN) begin
      nxt_sl_arm = 1'b0;
      nxt_dp_arm = 1'b0;
    end
  end

  // Reset leaves any mode at once; the clock still runs in idle, so
  // two machine cycles of reset are plenty.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      power_control_reg_ff   <= PWR_CTRL_RST;
      sl_arm_ff <= 1'b0;
      dp_arm_ff <= 1'b0;
      mode_ff   <= PSIC_RUN;
    end else begin
      power_control_reg_ff   <= nxt_power_control_reg;
      sl_arm_ff <= nxt_sl_arm;
      dp_arm_ff <= nxt_dp_arm;
      mode_ff   <= nxt_mode;
    end
  end

  // ============================================================
  // Clock gates and pin overrides, all registered.
  logic       nxt_cpu_en;
  logic       nxt_wdt_en;
  psic_pins_t nxt_pins;

  always_comb begin
    // Only the CPU and watchdog gates exist; peripherals, ports and
    // interrupt inputs run untouched, and frozen CPU clock keeps state.
    nxt_cpu_en = (nxt_mode == PSIC_RUN);
    nxt_wdt_en = (nxt_mode == PSIC_RUN);
    nxt_pins.ale         = core_ale;
    nxt_pins.prog_strobe = core_prog_strobe;
    nxt_pins.p0_oe       = 1'b1;
    nxt_pins.p2_addr_sel = ext_code_fetch;
    case (nxt_mode)
      PSIC_IDLE: begin
        nxt_pins.ale         = 1'b1;
        nxt_pins.prog_strobe = 1'b1;
        nxt_pins.p0_oe       = !ext_code_fetch;
        nxt_pins.p2_addr_sel = ext_code_fetch;
      end
      PSIC_DEEP: begin
        nxt_pins.ale         = 1'b0;
        nxt_pins.prog_strobe = !ext_code_fetch;
        nxt_pins.p0_oe       = !ext_code_fetch;
        nxt_pins.p2_addr_sel = 1'b0;
      end
      default: begin
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      cpu_clk_en        <= 1'b1;
      wdt_clk_en        <= 1'b1;
      wdt_auto_start    <= 1'b0;
      idle_active       <= 1'b0;
      deep_stop_active  <= 1'b0;
      save_permitted    <= 1'b0;
      power_control_reg <= PWR_CTRL_RST;
      pins              <= '{ale: 1'b1, prog_strobe: 1'b1,
                             p0_oe: 1'b1, p2_addr_sel: 1'b0};
    end else begin
      cpu_clk_en        <= nxt_cpu_en;
      wdt_clk_en        <= nxt_wdt_en;
      wdt_auto_start    <= nxt_wdt_auto;
      idle_active       <= (nxt_mode == PSIC_IDLE);
      deep_stop_active  <= (nxt_mode == PSIC_DEEP);
      save_permitted    <= nxt_permit;
      power_control_reg <= nxt_power_control_reg;
      pins              <= nxt_pins;
    end
  end

endmodule : psic_ctrl

// *** psic_pkg.sv ***
// Constants and carriers for the power-save and idle controller.
// Assumes one 50 MHz system clock and a core that reports SFR writes,
// instruction boundaries and machine-cycle state/phase timing.
// ============================================================
// Overview of operation
// - Permit pin high blocks every power-save entry.
// - Watchdog autostarts only if pin high at reset.
// - Pin low: modes usable, watchdog needs software.
// - Floating permit pin reads high by pull-up.
// - Later pin changes never touch the watchdog.
// - Pin sampled once per cycle, state 3 phase 1.
// - Idle gates CPU and watchdog clocks; peripherals run.
// - CPU state frozen unchanged through idle.
// - Ports and alternate outputs keep driving in idle.
// - Latch and program strobes held high in idle.
// - External fetch idle: port 0 floats; deep stop strobes low (code holds prog_strobe high in deep stop without external fetch).
// - Watchdog alone halts in idle, resumes after (code gates the CPU clock in idle as well).
// - Port inputs stay live during idle.
// - Arm and start written together do nothing.
// - Arm and start bits self-clear, read zero.
// - Start-bit instruction is last before gating.
// - Enabled interrupt ends idle, resumes after start.
// - Reset ends idle; two machine cycles suffice.
// - Power control register layout at 87H.
// - Deep stop wins over simultaneous idle request.
package psic_pkg;

  // ============================================================
  // Power control register.
  localparam logic [7:0] PWR_CTRL_ADDR   = 8'h87;
  localparam int         BIT_BAUD_DBL    = 7;
  localparam int         BIT_DEEP_START  = 6;
  localparam int         BIT_SLEEP_START = 5;
  localparam int         BIT_SLOW_DOWN   = 4;
  localparam int         BIT_GEN_FLAG1   = 3;
  localparam int         BIT_GEN_FLAG0   = 2;
  localparam int         BIT_DEEP_ARM    = 1;
  localparam int         BIT_SLEEP_ARM   = 0;
  localparam logic [7:0] PWR_CTRL_RST    = 8'h00;
  localparam logic [7:0] PWR_SELF_CLR    = 8'h63;

  // ============================================================
  // Machine-cycle timing.
  localparam logic [2:0] SAMPLE_STATE    = 3'h3;
  localparam logic       SAMPLE_PHASE    = 1'h1;
  localparam int         RST_MIN_CYCLES  = 2;

  typedef enum logic [1:0] {
    PSIC_RUN,
    PSIC_IDLE,
    PSIC_DEEP
  } psic_mode_t;

  typedef struct packed {
    logic       wr;
    logic [7:0] addr;
    logic [7:0] data;
  } psic_sfr_wr_t;

  typedef struct packed {
    logic       ale;
    logic       prog_strobe;
    logic       p0_oe;
    logic       p2_addr_sel;
  } psic_pins_t;

endpackage : psic_pkg

// *** psic_cycle_model.sv ***
// Machine-cycle sequencer model for the core side of the controller.
// Assumes the system clock; twelve clocks make one machine cycle.
`timescale 1ns/1ns
module psic_cycle_model (
  input  wire logic       sys_clk,
  input  wire logic       rst_b,
  output logic [2:0]      cyc_state,
  output logic            cyc_phase
);
  logic [3:0] cnt_ff;
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) cnt_ff <= 4'h0;
    else cnt_ff <= (cnt_ff == 4'hb) ? 4'h0 : cnt_ff + 4'h1;
  end
  // Six states of two phases; the sample slot recurs once per cycle.
  assign cyc_state = cnt_ff[3:1] + 3'h1;
  assign cyc_phase = ~cnt_ff[0];
endmodule : psic_cycle_model

// *** psic_checker.sv ***
// Port assertions for the idle controller.
// Assumes it is bound onto psic_ctrl and sees its ports by name.
`timescale 1ns/1ns
module psic_checker
  import psic_pkg::*;
(
  input wire logic         sys_clk,
  input wire logic         rst_b,
  input wire logic         instr_end,
  input wire psic_sfr_wr_t sfr_wr,
  input wire logic         irq_pending,
  input wire logic         cpu_clk_en,
  input wire logic         wdt_clk_en,
  input wire logic         wdt_auto_start,
  input wire logic         idle_active,
  input wire logic         save_permitted,
  input wire logic [7:0]   power_control_reg,
  input wire psic_pins_t   pins
);
  // ============================================================
  // Properties.
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  logic pc_wr;
  assign pc_wr = instr_end && sfr_wr.wr && sfr_wr.addr == PWR_CTRL_ADDR;
  sequence s_both;
    pc_wr && sfr_wr.data[BIT_SLEEP_ARM] && sfr_wr.data[BIT_SLEEP_START];
  endsequence
  property p_strobe; idle_active |-> pins.ale && pins.prog_strobe; endproperty
  property p_gate; idle_active |-> !cpu_clk_en && !wdt_clk_en; endproperty
  property p_cause;
    $rose(idle_active) |-> $past(pc_wr && sfr_wr.data[BIT_SLEEP_START]);
  endproperty
  property p_both; s_both |=> !$rose(idle_active); endproperty
  property p_rdzero; (power_control_reg & PWR_SELF_CLR) == 8'h00; endproperty
  // The strap lands on the first edge after release, so the check only
  // begins once two edges have passed out of reset.
  property p_strap; $past(rst_b, 2) |-> $stable(wdt_auto_start); endproperty
  property p_wake; idle_active && irq_pending |=> !idle_active; endproperty
  property p_permit; $rose(idle_active) |-> save_permitted; endproperty
  a_strobe: assert property (p_strobe) else $error("strobe low");
  a_gate: assert property (p_gate) else $error("clock on");
  a_cause: assert property (p_cause) else $error("bad entry");
  a_both: assert property (p_both) else $error("joint write");
  a_rdzero: assert property (p_rdzero) else $error("bits read");
  a_strap: assert property (p_strap) else $error("strap moved");
  a_wake: assert property (p_wake) else $error("no wake");
  a_permit: assert property (p_permit) else $error("blocked");
endmodule : psic_checker
bind psic_ctrl psic_checker u_psic_checker (.*);

// *** tb_psic_ctrl.sv ***
// Self-checking bench for the idle controller.
// Assumes the cycle model supplies machine-cycle timing.
`timescale 1ns/1ns
module tb_psic_ctrl
  import psic_pkg::*;
;
  logic sys_clk = 1'b0, rst_b = 1'b0, pin = 1'b1, conn = 1'b1;
  logic instr_end = 1'b0, irq = 1'b0, ext = 1'b0;
  psic_sfr_wr_t sfr_wr = '0;
  logic [2:0] cst;
  logic cph, cpu, wclk, wauto, idle, deep, perm;
  logic [7:0] pcr;
  psic_pins_t pins;
  int failures = 0, checks_done = 0, cyc = 0;
  always #10 sys_clk = ~sys_clk;
  psic_cycle_model u_psic_cycle_model (.sys_clk(sys_clk), .rst_b(rst_b),
    .cyc_state(cst), .cyc_phase(cph));
  psic_ctrl u_psic_ctrl (.sys_clk(sys_clk), .rst_b(rst_b),
    .power_save_permit_pin(pin), .permit_pin_connected(conn),
    .cyc_state(cst), .cyc_phase(cph), .instr_end(instr_end),
    .sfr_wr(sfr_wr), .irq_pending(irq), .ext_code_fetch(ext),
    .core_ale(1'b0), .core_prog_strobe(1'b0), .cpu_clk_en(cpu),
    .wdt_clk_en(wclk), .wdt_auto_start(wauto), .idle_active(idle),
    .deep_stop_active(deep), .save_permitted(perm),
    .power_control_reg(pcr), .pins(pins));
  // ============================================================
  // Shared tasks.
  task automatic results;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : results
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic rst(input logic p, input logic c, input int n);
    @(negedge sys_clk);
    rst_b <= 1'b0;
    pin <= p;
    conn <= c;
    repeat (n) @(negedge sys_clk);
    rst_b <= 1'b1;
    repeat (14) @(negedge sys_clk);
  endtask : rst
  // One power control write; the environment keeps them in order.
  task automatic wr(input logic [7:0] d);
    @(negedge sys_clk);
    sfr_wr <= '{1'b1, PWR_CTRL_ADDR, d};
    instr_end <= 1'b1;
    @(negedge sys_clk);
    sfr_wr.wr <= 1'b0;
    instr_end <= 1'b0;
  endtask : wr
  // ============================================================
  // Scenarios.
  task automatic t_strap;
    rst(1'b1, 1'b1, 20);
    pin <= 1'b0;
    repeat (14) @(negedge sys_clk);
    chk(8'({wauto, perm}), 8'h3);
    rst(1'b0, 1'b1, 20);
    chk(8'(wauto), 8'h0);
    rst(1'b0, 1'b0, 20);
    chk(8'({wauto, perm}), 8'h2);
  endtask : t_strap
  task automatic t_idle(input logic e);
    rst(1'b0, 1'b1, 20);
    ext <= e;
    wr(8'h01);
    wr(8'h20);
    repeat (5) @(negedge sys_clk);
    chk(8'({idle, cpu, wclk, pins.ale, pins.prog_strobe}), 8'h13);
    chk(pcr, 8'h00);
    chk(8'({pins.p0_oe, pins.p2_addr_sel}), e ? 8'h1 : 8'h2);
    irq <= 1'b1;
    @(negedge sys_clk);
    irq <= 1'b0;
    chk(8'({idle, cpu, wclk}), 8'h3);
  endtask : t_idle
  task automatic t_refuse;
    rst(1'b0, 1'b1, 20);
    wr(8'h21);
    wr(8'h01);
    wr(8'h00);
    wr(8'h20);
    pin <= 1'b1;
    repeat (14) @(negedge sys_clk);
    wr(8'h01);
    wr(8'h20);
    chk(8'({idle, cpu}), 8'h1);
  endtask : t_refuse
  task automatic t_deep;
    rst(1'b0, 1'b1, 20);
    ext <= 1'b1;
    wr(8'h03);
    wr(8'h60);
    chk(8'({deep, idle, pins.ale, pins.prog_strobe}), 8'h8);
    rst(1'b0, 1'b1, 20);
    wr(8'h01);
    wr(8'h20);
    rst(1'b0, 1'b1, 24);
    chk(8'({deep, idle, cpu}), 8'h1);
  endtask : t_deep
  // ============================================================
  // Main sequence and hang guard.
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      results();
    end
  end
  initial begin
    t_strap();
    t_idle(1'b0);
    t_idle(1'b1);
    t_refuse();
    t_deep();
    results();
  end
endmodule : tb_psic_ctrl
